// file: include/adc_port_pkg.sv
// Purpose: shared constants and types for the converter serial command port
// Assumes: 24-bit registers, 8-bit commands, most significant bit first
// Notes: configuration bit positions for flags not fixed elsewhere are local picks
`default_nettype none
package adc_port_pkg;
   // command byte fields, most significant bit first
   typedef struct packed {
      logic cb;
      logic sc;
      logic cc;
      logic rw;
      logic [2:0] rsel;
      logic ps;
   } command_t;

   typedef enum logic {PORT_CMD, PORT_DATA} port_state_t;

   localparam int CMD_BITS = 8;
   localparam int WORD_BITS = 24;
   localparam int SETUP_BITS = 72;
   localparam int RESYNC_FILL_MIN = 15;
   localparam int POR_OSC_CYCLES = 1002;
   localparam int POR_CNT_W = 10;

   // bit counts at the width of the port counters
   localparam logic [6:0] CMD_LAST = 7'(CMD_BITS - 1);
   localparam logic [6:0] WORD_LEN = 7'(WORD_BITS);
   localparam logic [6:0] SETUP_LEN = 7'(SETUP_BITS);
   // fifteen fill bytes of ones plus the seven leading ones of the end byte
   localparam logic [6:0] RESYNC_ONES = 7'(RESYNC_FILL_MIN * CMD_BITS + CMD_BITS - 1);

   localparam logic [7:0] NULL_CMD = 8'h00;

   // register select codes
   localparam logic [2:0] RSEL_OFFSET = 3'h0;
   localparam logic [2:0] RSEL_GAIN = 3'h1;
   localparam logic [2:0] RSEL_CONFIG = 3'h2;
   localparam logic [2:0] RSEL_DATA = 3'h3;
   localparam logic [2:0] RSEL_SETUP = 3'h4;

   // reset values
   localparam logic [23:0] CFG_RESET = 24'h000040;
   localparam logic [23:0] OFFSET_RESET = 24'h000000;
   localparam logic [23:0] GAIN_RESET = 24'h400000;

   // configuration field positions
   localparam int CFG_ALATCH_HI = 23;
   localparam int CFG_ALATCH_LO = 22;
   localparam int CFG_DLATCH_HI = 21;
   localparam int CFG_DLATCH_LO = 18;
   localparam int CFG_LOW_POWER = 16;
   localparam int CFG_WR_HI = 15;
   localparam int CFG_WR_LO = 13;
   localparam int CFG_RS = 7;
   localparam int CFG_RV = 6;
   localparam int CFG_PF = 5;
   localparam int CFG_PSS = 4;
endpackage
`default_nettype wire

// file: rtl/adc_serial_command_port_ctrl.sv
// Purpose: serial command port, register file and reset control of the converter
// Assumes: host drives sclk_in, samples serial_out_out on rising edges
// Notes: shifting runs on sclk_in; registers and resets run on clock_in
`timescale 1ns/1ns
`default_nettype none
// Operation
// - select code 100 moves 72 bits: offset, gain, then configuration
// - serial output released whenever chip select is high
// - serial clock edges ignored while chip select is high
// - chip select tied low gives a working three-wire port
// - fifteen or more 0xff bytes then 0xfe return port to command mode
// - resync touches only port state, never register contents
// - power-up reset lasts until 1002 oscillator cycles have been counted
// - during that timeout port held in reset and reset-valid flag set
// - power-up reset loads config 000040, offset 000000, gain 400000, command mode; soft reset loads config 0000c0
// - writing one to soft-reset bit starts a system reset anytime
// - reset-valid stays set until configuration register is read
// - four digital latch pins follow configuration bits 21 to 18
// - two analog latch pins follow configuration bits 23 and 22
// - normal power after reset; bit 16 one selects low power
// - command 0x81 enters power save, stopping analog and filter
// - bit 4 zero picks standby, one picks sleep
// - a run command leaves standby promptly
// - word-rate bits set output rate; reset picks the 15 sps code
// - register access command enters data mode for 24 clocks (72 for setup), then command mode
// - command bits: valid, single, continuous, read, power save
// - select codes 000 to 011 pick offset, gain, config, data
// - null command clears port flag in continuous port-flag mode
module adc_serial_command_port_ctrl #(
   parameter int POR_CYCLES = adc_port_pkg::POR_OSC_CYCLES
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic serial_in_in,
   output logic serial_out_out,
   output logic serial_out_en_n_out,
   input wire logic osc_in,
   input wire logic [23:0] conv_data_in,
   input wire logic conv_ready_in,
   output logic [3:0] digital_latch_pins_out,
   output logic [1:0] analog_latch_pins_out,
   output logic low_power_out,
   output logic standby_out,
   output logic sleep_out,
   output logic [2:0] word_rate_select_out,
   output logic device_reset_out,
   output logic convert_single_out,
   output logic convert_continuous_out
);
   import adc_port_pkg::*;

   // system-domain registers seen by the link side as held words
   logic [23:0] offset, gain, cfg, conv_hold;
   logic por_busy, flag_armed, sdo_ready;

   // ---------------- link side, clocked by sclk_in ----------------
   logic [2:0] link_s;
   // power-up values: the link clock may not tick before the first frame
   port_state_t state = PORT_CMD;
   logic [6:0] bit_cnt = 7'h00;
   logic [6:0] ones_run = 7'h00;
   logic cmd_tgl = 1'b0;
   logic wr_tgl = 1'b0;
   logic busy = 1'b0;
   logic sdo_q = 1'b0;
   logic [6:0] data_len;
   logic [6:0] cmd_shift;
   logic [71:0] in_shift, out_shift;
   command_t cmd_hold;
   logic frame_rw;

   sig_sync #(.W(3)) u_link_sync (
      .clk_in(sclk_in),
      .d_in({por_busy, flag_armed, sdo_ready}),
      .q_out(link_s)
   );

   // command decode at the eighth bit
   wire port_rst = link_s[2];
   wire armed_l = link_s[1];
   wire ready_l = link_s[0];
   wire link_active = !cs_n_in && !port_rst;
   wire resync_hit = !serial_in_in && (ones_run >= RESYNC_ONES);
   wire step = link_active && !resync_hit;
   wire [7:0] rx_byte = {cmd_shift, serial_in_in};
   command_t rx_cmd;
   assign rx_cmd = command_t'(rx_byte);
   wire byte_done = step && state == PORT_CMD && bit_cnt == CMD_LAST;
   wire null_read = rx_byte == NULL_CMD && armed_l;
   wire rsel_ok = rx_cmd.rsel <= RSEL_SETUP;
   wire reg_access = rx_cmd.cb && !rx_cmd.sc && !rx_cmd.cc && !rx_cmd.ps && rsel_ok;
   wire start_data = byte_done && (reg_access || null_read);
   wire [2:0] next_sel = null_read ? RSEL_DATA : rx_cmd.rsel;
   wire next_rw = null_read || rx_cmd.rw;
   wire frame_end = step && state == PORT_DATA && bit_cnt == data_len - 7'h01;

   // read image picked at command time; held words are stable while busy
   wire [23:0] sel_word = (next_sel == RSEL_OFFSET) ? offset :
                          (next_sel == RSEL_GAIN) ? gain :
                          (next_sel == RSEL_CONFIG) ? cfg : conv_hold;
   wire [71:0] rd_load = (next_sel == RSEL_SETUP) ? {offset, gain, cfg} :
                         {sel_word, 48'h000000000000};

   // run of consecutive ones, saturating, for resync detection
   always_ff @(posedge sclk_in) begin
      if (port_rst) begin
         ones_run <= 7'h00;
      end else if (!cs_n_in) begin
         ones_run <= !serial_in_in ? 7'h00 :
                     (ones_run == RESYNC_ONES) ? ones_run : ones_run + 7'h01;
      end
   end

   // port mode and bit counter; resync restores command mode only
   always_ff @(posedge sclk_in) begin
      if (port_rst || (link_active && resync_hit)) begin
         state <= PORT_CMD;
         bit_cnt <= 7'h00;
         busy <= 1'b0;
      end else if (byte_done) begin
         state <= start_data ? PORT_DATA : PORT_CMD;
         bit_cnt <= 7'h00;
         busy <= start_data;
      end else if (frame_end) begin
         state <= PORT_CMD;
         bit_cnt <= 7'h00;
         busy <= 1'b0;
      end else if (step) begin
         bit_cnt <= bit_cnt + 7'h01;
         busy <= 1'b1;
      end
   end

   // command capture and frame setup
   always_ff @(posedge sclk_in) begin
      if (byte_done) begin
         cmd_hold <= rx_cmd;
         cmd_tgl <= ~cmd_tgl;
         frame_rw <= next_rw;
         data_len <= (next_sel == RSEL_SETUP) ? SETUP_LEN : WORD_LEN;
      end
      if (frame_end && !frame_rw) begin
         wr_tgl <= ~wr_tgl;
      end
   end

   // data shifters, msb first in both directions
   always_ff @(posedge sclk_in) begin
      if (byte_done && next_rw) begin
         out_shift <= rd_load;
      end else if (step && state == PORT_DATA) begin
         out_shift <= {out_shift[70:0], 1'b0};
      end
      if (step && state == PORT_CMD) begin
         cmd_shift <= rx_byte[6:0];
      end
      if (step && state == PORT_DATA) begin
         in_shift <= {in_shift[70:0], serial_in_in};
      end
   end

   // output changes on the falling edge so the host samples on the rising one
   always_ff @(negedge sclk_in) begin
      if (!cs_n_in) begin
         sdo_q <= (state == PORT_DATA && frame_rw) ? out_shift[71] : (armed_l && !ready_l);
      end
   end

   assign serial_out_out = sdo_q;
   assign serial_out_en_n_out = cs_n_in;

   // ---------------- system side, clocked by clock_in ----------------
   logic [3:0] sys_s;
   logic [3:0] sys_d = 4'h0;
   logic [POR_CNT_W-1:0] por_cnt;
   logic convert_single, standby, sleep, continuous;

   sig_sync #(.W(4)) u_sys_sync (
      .clk_in(clock_in),
      .d_in({osc_in, wr_tgl, cmd_tgl, busy}),
      .q_out(sys_s)
   );

   // edge detectors read only the second synchroniser stage
   always_ff @(posedge clock_in) begin
      sys_d <= sys_s;
   end

   wire osc_rise = sys_s[3] && !sys_d[3];
   wire wr_evt = sys_s[2] ^ sys_d[2];
   wire cmd_evt = sys_s[1] ^ sys_d[1];
   wire port_busy = sys_s[0];
   wire in_reset = !resetn_in || por_busy;

   // held command and write word stay still until the next byte completes
   wire [23:0] wr_low = in_shift[23:0];
   wire is_setup = cmd_hold.rsel == RSEL_SETUP;
   wire do_write = wr_evt && !cmd_hold.rw;
   wire hit_off = do_write && (cmd_hold.rsel == RSEL_OFFSET || is_setup);
   wire hit_gain = do_write && (cmd_hold.rsel == RSEL_GAIN || is_setup);
   wire hit_cfg = do_write && (cmd_hold.rsel == RSEL_CONFIG || is_setup);
   wire soft_rst = hit_cfg && wr_low[CFG_RS];
   wire sys_access = cmd_hold.cb && !cmd_hold.sc && !cmd_hold.cc && !cmd_hold.ps &&
                     (cmd_hold.rsel <= RSEL_SETUP);
   wire rv_clear = cmd_evt && sys_access && cmd_hold.rw &&
                   (cmd_hold.rsel == RSEL_CONFIG || is_setup);
   wire exec_evt = cmd_evt && cmd_hold.cb && (cmd_hold.rsel <= RSEL_SETUP);
   wire null_evt = cmd_evt && command_t'(NULL_CMD) == cmd_hold;
   wire [23:0] cfg_written = {wr_low[23:CFG_RV+1], cfg[CFG_RV], wr_low[CFG_RV-1:0]};

   // power-up timeout counted on synchronised oscillator edges
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         por_busy <= 1'b1;
         por_cnt <= '0;
      end else if (por_busy && osc_rise) begin
         por_cnt <= por_cnt + POR_CNT_W'(1);
         por_busy <= por_cnt != POR_CNT_W'(POR_CYCLES - 1);
      end
   end

   // calibration registers
   always_ff @(posedge clock_in) begin
      if (in_reset || soft_rst) begin
         offset <= OFFSET_RESET;
         gain <= GAIN_RESET;
      end else begin
         if (hit_off) offset <= is_setup ? in_shift[71:48] : wr_low;
         if (hit_gain) gain <= is_setup ? in_shift[47:24] : wr_low;
      end
   end

   // configuration; soft reset keeps the soft-reset bit until the host clears it
   always_ff @(posedge clock_in) begin
      if (in_reset) begin
         cfg <= CFG_RESET;
      end else if (soft_rst) begin
         cfg <= CFG_RESET | (24'h000001 << CFG_RS);
      end else if (hit_cfg) begin
         cfg <= cfg_written;
      end else if (rv_clear) begin
         cfg[CFG_RV] <= 1'b0;
      end
   end

   // power save and conversion control
   always_ff @(posedge clock_in) begin
      if (in_reset || soft_rst) begin
         standby <= 1'b0;
         sleep <= 1'b0;
         continuous <= 1'b0;
      end else if (exec_evt) begin
         standby <= cmd_hold.ps && !cfg[CFG_PSS];
         sleep <= cmd_hold.ps && cfg[CFG_PSS];
         continuous <= !cmd_hold.ps && (cmd_hold.cc || (continuous && !cmd_hold.sc));
      end
   end

   // single conversion strobe and port flag; a new word beats the null clear
   always_ff @(posedge clock_in) begin
      if (in_reset) begin
         convert_single <= 1'b0;
         flag_armed <= 1'b0;
         sdo_ready <= 1'b0;
         conv_hold <= 24'h000000;
      end else begin
         convert_single <= exec_evt && cmd_hold.sc && !cmd_hold.ps;
         flag_armed <= continuous && cfg[CFG_PF];
         if (conv_ready_in && flag_armed) sdo_ready <= 1'b1;
         else if (null_evt) sdo_ready <= 1'b0;
         if (conv_ready_in && !port_busy) conv_hold <= conv_data_in;
      end
   end

   assign digital_latch_pins_out = cfg[CFG_DLATCH_HI:CFG_DLATCH_LO];
   assign analog_latch_pins_out = cfg[CFG_ALATCH_HI:CFG_ALATCH_LO];
   assign low_power_out = cfg[CFG_LOW_POWER];
   assign word_rate_select_out = cfg[CFG_WR_HI:CFG_WR_LO];
   assign standby_out = standby;
   assign sleep_out = sleep;
   assign device_reset_out = por_busy || cfg[CFG_RS];
   assign convert_single_out = convert_single;
   assign convert_continuous_out = continuous;

   // ---------------- checks ----------------
   property p_sdo_release;
      @(posedge clock_in) disable iff (!resetn_in) cs_n_in |-> serial_out_en_n_out;
   endproperty
   a_sdo_release: assert property (p_sdo_release) else $error("serial out driven with cs high");

   property p_por_len;
      @(posedge clock_in) disable iff (!resetn_in) $fell(por_busy) |-> $past(osc_rise) &&
         $past(por_cnt) == POR_CNT_W'(POR_CYCLES - 1);
   endproperty
   a_por_len: assert property (p_por_len) else $error("power-up timeout wrong length");

   property p_por_values;
      @(posedge clock_in) disable iff (!resetn_in) por_busy |=>
         cfg == CFG_RESET && gain == GAIN_RESET && offset == OFFSET_RESET;
   endproperty
   a_por_values: assert property (p_por_values) else $error("reset values not loaded");

   property p_soft_reset;
      @(posedge clock_in) disable iff (in_reset) soft_rst |=>
         gain == GAIN_RESET && device_reset_out && cfg[CFG_RV];
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not taken");

   property p_rv_clear;
      @(posedge clock_in) disable iff (in_reset) rv_clear && !wr_evt |=> !cfg[CFG_RV];
   endproperty
   a_rv_clear: assert property (p_rv_clear) else $error("reset-valid not cleared on read");

   property p_latch_follow;
      @(posedge clock_in) disable iff (in_reset) hit_cfg && !soft_rst |=>
         digital_latch_pins_out == $past(wr_low[CFG_DLATCH_HI:CFG_DLATCH_LO]) &&
         analog_latch_pins_out == $past(wr_low[CFG_ALATCH_HI:CFG_ALATCH_LO]);
   endproperty
   a_latch_follow: assert property (p_latch_follow) else $error("latch pins lag config");

   property p_power_save;
      @(posedge clock_in) disable iff (in_reset || soft_rst) exec_evt && cmd_hold.ps |=>
         standby_out == !$past(cfg[CFG_PSS]) && sleep_out == $past(cfg[CFG_PSS]);
   endproperty
   a_power_save: assert property (p_power_save) else $error("wrong power save mode");

   property p_run;
      @(posedge clock_in) disable iff (in_reset) exec_evt && !cmd_hold.ps |=>
         !standby_out && !sleep_out;
   endproperty
   a_run: assert property (p_run) else $error("run did not leave power save");

   property p_resync;
      @(posedge sclk_in) disable iff (port_rst) link_active && resync_hit |=>
         state == PORT_CMD && bit_cnt == 7'h00;
   endproperty
   a_resync: assert property (p_resync) else $error("resync missed");

   property p_reserved;
      @(posedge sclk_in) disable iff (port_rst) byte_done && rx_cmd.cb && !rsel_ok |=>
         state == PORT_CMD;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved select left command mode");

   property p_setup_len;
      @(posedge sclk_in) disable iff (port_rst) start_data && next_sel == RSEL_SETUP |=>
         data_len == SETUP_LEN && state == PORT_DATA;
   endproperty
   a_setup_len: assert property (p_setup_len) else $error("setup frame not 72 bits");

   c_soft_reset: cover property (@(posedge clock_in) disable iff (in_reset) soft_rst);
   c_resync: cover property (@(posedge sclk_in) disable iff (port_rst) link_active && resync_hit);
   c_setup_write: cover property (@(posedge clock_in) disable iff (in_reset) hit_off && is_setup);
   c_sleep: cover property (@(posedge clock_in) disable iff (in_reset) $rose(sleep_out));
endmodule // adc_serial_command_port_ctrl
`default_nettype wire

// file: rtl/sig_sync.sv
// Purpose: two-stage synchroniser, one stage pair per bit
// Assumes: inputs are levels or toggles that hold for several destination clocks
// Notes: power-up value zero so a stopped link clock never yields unknowns
`timescale 1ns/1ns
`default_nettype none
module sig_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   // per-bit pair; only the second stage is visible outside
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta = 1'b0;
      logic hold = 1'b0;
      always_ff @(posedge clk_in) begin
         meta <= d_in[i];
         hold <= meta;
      end
      assign q_out[i] = hold;
   end
endmodule // sig_sync
`default_nettype wire

// file: tb/adc_serial_command_port_ctrl_test.sv
// Purpose: self-checking bench of the converter serial command port
// Assumes: power-up count shortened to 8 oscillator cycles
// Notes: random register values come from a fixed-seed shift register
`timescale 1ns/1ns
`default_nettype none
module adc_serial_command_port_ctrl_test;
   import adc_port_pkg::*;
   localparam int POR_SIM = 8;
   logic clock_in, resetn_in, osc, conv_ready, sclk, cs_n, din, dout, dout_en_n;
   logic low_power, standby, sleep_mode, dev_reset, conv_single, conv_cont;
   logic [23:0] conv_data, cfg, off, gain, w;
   logic [3:0] dlatch;
   logic [1:0] alatch;
   logic [2:0] wrate;
   logic [79:0] rx80;
   logic [71:0] s;
   logic [15:0] lfsr = 16'h2b8a;
   int err_total = 0;
   int n_compared = 0;
   int oscs, k;
   int n_single = 0;
   logic prev;

   adc_serial_command_port_ctrl #(.POR_CYCLES(POR_SIM)) i_adc_serial_command_port_ctrl (
      .clock_in(clock_in), .resetn_in(resetn_in), .sclk_in(sclk), .cs_n_in(cs_n),
      .serial_in_in(din), .serial_out_out(dout), .serial_out_en_n_out(dout_en_n),
      .osc_in(osc), .conv_data_in(conv_data), .conv_ready_in(conv_ready),
      .digital_latch_pins_out(dlatch), .analog_latch_pins_out(alatch),
      .low_power_out(low_power), .standby_out(standby), .sleep_out(sleep_mode),
      .word_rate_select_out(wrate), .device_reset_out(dev_reset),
      .convert_single_out(conv_single), .convert_continuous_out(conv_cont));

   host_model i_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .data_to_dev_out(din),
      .data_from_dev_in(dout));

   function automatic logic [15:0] step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   function automatic logic [23:0] rnd24();
      logic [15:0] a;
      a = step(lfsr);
      lfsr = step(a);
      return {a[11:4], lfsr};
   endfunction

   task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one command plus len data bits; writes land a few clocks after the frame
   task automatic op(input logic [7:0] cmd, input int len, input logic [71:0] data);
      @(posedge clock_in);
      #1;
      i_host_model.xfer((80'(cmd) << len) | 80'(data), 8 + len, rx80);
      repeat (6) @(posedge clock_in);
      #1; // look between edges, never in the step that launches an output
      check("out_released", dout_en_n, 1'b1);
   endtask

   task automatic rd(input logic [7:0] cmd, input int len, input logic [71:0] exp, string nm);
      op(cmd, len, 72'h0);
      check(nm, rx80[71:0], exp);
   endtask

   task automatic pins(input logic [23:0] c);
      check("latch_pins", {alatch, dlatch}, c[23:18]);
      check("low_power", low_power, c[16]);
      check("word_rate", wrate, c[15:13]);
   endtask

   task automatic new_word(input logic [23:0] v);
      conv_data = v;
      conv_ready = 1'b1;
      @(posedge clock_in);
      #1;
      conv_ready = 1'b0;
   endtask

   // system clock, 4 ns
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end

   // oscillator pin, ten system clocks a period
   initial begin
      osc = 1'b0;
      forever begin
         repeat (5) @(posedge clock_in);
         #1 osc = ~osc;
      end
   end

   // single conversion strobe lasts one clock, so count pulses as they pass
   always @(posedge clock_in) begin
      if (conv_single === 1'b1) n_single++;
   end

   // hang guard
   initial begin
      repeat (99000) @(posedge clock_in);
      err_total++;
      $display("mismatch watchdog expected finish seen hang");
      complete_run();
   end

   initial begin
      resetn_in = 1'b0;
      conv_data = 24'h0;
      conv_ready = 1'b0;
      repeat (12) @(posedge clock_in);
      #1;
      pins(CFG_RESET);
      check("reset_hold", dev_reset, 1'b1);
      resetn_in = 1'b1;
      oscs = 0;
      prev = osc;
      for (k = 0; k < 2000 && dev_reset !== 1'b0; k++) begin
         @(posedge clock_in);
         if (osc && !prev) oscs++;
         prev = osc;
      end
      if (k == 2000) begin
         err_total++;
         $display("mismatch por_wait expected release seen hang");
         complete_run();
      end
      check("por_length", oscs >= POR_SIM && oscs <= POR_SIM + 1, 1'b1);
      repeat (120) @(posedge clock_in);
      rd(8'h94, 24, CFG_RESET, "cfg_reset_valid");
      rd(8'h94, 24, 24'h0, "cfg_valid_cleared");
      rd(8'h90, 24, OFFSET_RESET, "offset_reset");
      rd(8'h92, 24, GAIN_RESET, "gain_reset");
      // random register traffic, one chip-select frame per access
      repeat (4) begin
         cfg = rnd24() & 24'hffff3f;
         off = rnd24();
         gain = rnd24();
         op(8'h84, 24, cfg);
         pins(cfg);
         op(8'h80, 24, off);
         op(8'h82, 24, gain);
         op(8'h86, 24, rnd24());
         rd(8'h98, 72, {off, gain, cfg}, "setup_read");
      end
      s = {rnd24(), rnd24(), rnd24() & 24'hffff0f};
      op(8'h88, 72, s);
      {off, gain, cfg} = s;
      rd(8'h90, 24, off, "offset_wr");
      rd(8'h94, 24, cfg, "cfg_wr");
      w = rnd24();
      new_word(w);
      rd(8'h96, 24, w, "data_read");
      for (int c = 5; c < 8; c++) begin
         op({4'h8, 3'(c), 1'b0}, 0, 72'h0);
         rd(8'h92, 24, gain, "after_reserved");
      end
      i_host_model.stray_clocks(8);
      rd(8'h94, 24, cfg, "after_stray");
      // standby then sleep, selected by the save-mode bit loaded first
      for (int b = 0; b < 2; b++) begin
         op(8'h84, 24, {cfg[23:5], 1'(b), cfg[3:0]});
         op(8'h81, 0, 72'h0);
         check("save_mode", {standby, sleep_mode}, b ? 2'b01 : 2'b10);
         op(8'h80, 24, off);
         check("run_mode", {standby, sleep_mode}, 2'b00);
      end
      op(8'ha0, 0, 72'h0);
      check("continuous_on", conv_cont, 1'b1);
      op(8'hc0, 0, 72'h0);
      check("continuous_off", conv_cont, 1'b0);
      check("single_pulse", n_single, 1);
      cfg = {cfg[23:6], 2'b10, cfg[3:0]};
      op(8'h84, 24, cfg);
      op(8'ha0, 0, 72'h0);
      w = rnd24();
      new_word(w);
      rd(8'h00, 24, w, "flag_read");
      op(8'hc0, 0, 72'h0);
      // resync after a broken command byte
      i_host_model.xfer(80'h4, 3, rx80);
      i_host_model.xfer({16'h0, {64{1'b1}}}, 64, rx80);
      i_host_model.xfer({16'h0, {63{1'b1}}, 1'b0}, 64, rx80);
      rd(8'h94, 24, cfg, "resync_cfg");
      rd(8'h90, 24, off, "resync_offset");
      op(8'h84, 24, 24'hfc0080);
      check("soft_reset", dev_reset, 1'b1);
      pins(24'h0000c0);
      rd(8'h94, 24, 24'h0000c0, "soft_cfg");
      op(8'h84, 24, 24'h0);
      check("soft_release", dev_reset, 1'b0);
      rd(8'h98, 72, {OFFSET_RESET, GAIN_RESET, 24'h0}, "soft_regs");
      complete_run();
   end
endmodule // adc_serial_command_port_ctrl_test
`default_nettype wire

// file: tb/host_model.sv
// Purpose: host controller model driving the converter serial port
// Assumes: link clock of 125 ns, parked low and stopped between frames
// Notes: the data line has no pull; once released it shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module host_model (
   output logic sclk_out,
   output logic cs_n_out,
   output logic data_to_dev_out,
   input wire logic data_from_dev_in
);
   // idle: deselected, clock parked low
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      data_to_dev_out = 1'b0;
   end

   // one frame of n bits; returned bits are taken on each rising edge
   task automatic xfer(input logic [79:0] tx, input int n, output logic [79:0] rx);
      rx = '0;
      cs_n_out = 1'b0;
      #62;
      for (int i = n - 1; i >= 0; i--) begin
         data_to_dev_out = tx[i];
         #62;
         sclk_out = 1'b1;
         rx = {rx[78:0], data_from_dev_in};
         #63;
         sclk_out = 1'b0;
      end
      #62;
      cs_n_out = 1'b1;
      data_to_dev_out = ~data_to_dev_out; // a released line must not hold its value
   endtask

   // clock pulses while deselected; a correct port ignores them
   task automatic stray_clocks(input int n);
      data_to_dev_out = 1'b1;
      repeat (n) begin
         #62;
         sclk_out = 1'b1;
         #63;
         sclk_out = 1'b0;
      end
   endtask
endmodule // host_model
`default_nettype wire
